// ---- shared/sys_reset_pkg.sv ----
/*
  Package for the system reset and power state controller: state
  enumeration, source carrier struct, processor control struct and timing counts.
  Assumes a single 100 MHz clock domain.
*/
package sys_reset_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLOCK_PERIOD_NS = 10;
  // Least time a reset request stays asserted inside the core
  localparam int RESET_HOLD_NS = 1000;
  localparam int RESET_HOLD_CYCLES =
    (RESET_HOLD_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int HOLD_CNT_W = 8;
  localparam int GPIO_COUNT = 83;
  localparam int PROC_RESETS = 4;
  localparam int BLOCK_RESETS = 8;
  localparam int EXT_RESETS = 2;
  localparam int FRONT_CLOCKS = 4;
  localparam int MAIN_CLOCKS = 8;

  // ****************************************************************
  // Power mode values
  // ****************************************************************
  localparam logic POWER_MODE_NORMAL = 1'b0;
  localparam logic POWER_MODE_LOW = 1'b1;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [1:0] {
    ST_POR,
    ST_PLL_START,
    ST_RESET_HOLD,
    ST_RUN
  } seq_state_t;

  typedef struct packed {
    logic power_up;
    logic supply_loss;
    logic watchdog;
    logic lamp_strike;
  } reset_src_t;

  typedef struct packed {
    logic [BLOCK_RESETS-1:0] block_release;
    logic [EXT_RESETS-1:0] ext_release;
    logic link_pll_enable;
    logic link_clkgen_release;
    logic link_pads_enable;
    logic [FRONT_CLOCKS-1:0] front_clk_enable;
    logic low_power_req;
  } proc_ctrl_t;

endpackage : sys_reset_pkg

// ---- rtl/sys_reset_ctrl.sv ----
/*
  System reset and power state controller. Merges power-up, supply-loss,
  watchdog and lamp-strike sources into one system reset, sequences the
  master PLL after power-up only, and holds every block except the processor and master PLL in its
  safe reset state until the embedded processor releases it.
  Assumes: source inputs are asynchronous pins or other-domain levels;
  processor control inputs come from logic on CLOCK_I; PLL lock is a pin.
*/
module sys_reset_ctrl #(
  parameter int HOLD_CYCLES = sys_reset_pkg::RESET_HOLD_CYCLES,
  parameter int GPIO_W = sys_reset_pkg::GPIO_COUNT
) (
  input wire logic CLOCK_I,
  input wire logic RST_N_I,
  input wire sys_reset_pkg::reset_src_t SOURCES_I,
  input wire logic MASTER_PLL_LOCK_I,
  input wire sys_reset_pkg::proc_ctrl_t PROC_CTRL_I,
  input wire logic [GPIO_W-1:0] GPIO_CFG_OE_I,
  output logic MASTER_PLL_RESET_O,
  output logic POWER_MODE_O,
  output logic [GPIO_W-1:0] GPIO_OE_O,
  output logic [sys_reset_pkg::MAIN_CLOCKS-1:0] MAIN_CLK_EN_O,
  output logic PROC_FULL_RATE_O,
  output logic [sys_reset_pkg::PROC_RESETS-1:0] PROC_RESET_N_O,
  output logic [sys_reset_pkg::BLOCK_RESETS-1:0] BLOCK_RESET_N_O,
  output logic [sys_reset_pkg::EXT_RESETS-1:0] EXT_RESET_N_O,
  output logic LINK_PLL_POWER_DOWN_O,
  output logic LINK_CLKGEN_RESET_N_O,
  output logic LINK_PADS_POWER_DOWN_O,
  output logic [sys_reset_pkg::FRONT_CLOCKS-1:0] FRONT_CLK_EN_O,
  output logic SYS_RESET_ACTIVE_O
);

  // ****************************************************************
  // Reset release and input synchronisers
  // ****************************************************************
  logic [1:0] rst_sync_reg;
  logic rst_n;
  logic [3:0] src_meta_reg;
  logic [3:0] src_sync_reg;
  logic [1:0] lock_sync_reg;

  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_reg[1];

  always_ff @(posedge CLOCK_I or negedge rst_n) begin
    if (!rst_n) begin
      src_meta_reg <= 4'h0;
      src_sync_reg <= 4'h0;
      lock_sync_reg <= 2'h0;
    end else begin
      src_meta_reg <= SOURCES_I;
      src_sync_reg <= src_meta_reg;
      lock_sync_reg <= {lock_sync_reg[0], MASTER_PLL_LOCK_I};
    end
  end

  // ****************************************************************
  // Source decode
  // ****************************************************************
  sys_reset_pkg::reset_src_t src;
  logic any_src;
  logic pll_locked;

  assign src = sys_reset_pkg::reset_src_t'(src_sync_reg);
  assign any_src = |src_sync_reg;
  assign pll_locked = lock_sync_reg[1];

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  sys_reset_pkg::seq_state_t state_reg, state_next;
  logic [sys_reset_pkg::HOLD_CNT_W-1:0] hold_reg, hold_next;
  logic hold_done;

  localparam logic [sys_reset_pkg::HOLD_CNT_W-1:0] HOLD_LAST =
    sys_reset_pkg::HOLD_CNT_W'(HOLD_CYCLES - 1);

  assign hold_done = (hold_reg == HOLD_LAST);

  always_comb begin
    state_next = state_reg;
    hold_next = hold_reg;
    case (state_reg)
      sys_reset_pkg::ST_POR: begin
        state_next = sys_reset_pkg::ST_PLL_START;
      end
      sys_reset_pkg::ST_PLL_START: begin
        hold_next = '0;
        if (pll_locked) begin
          state_next = sys_reset_pkg::ST_RESET_HOLD;
        end
      end
      sys_reset_pkg::ST_RESET_HOLD: begin
        if (any_src) begin
          hold_next = '0;
        end else if (!hold_done) begin
          hold_next = hold_reg + 1'b1;
        end else begin
          state_next = sys_reset_pkg::ST_RUN;
        end
      end
      sys_reset_pkg::ST_RUN: begin
        hold_next = '0;
        if (any_src) begin
          state_next = sys_reset_pkg::ST_RESET_HOLD;
        end
      end
      default: begin
        state_next = sys_reset_pkg::ST_POR;
      end
    endcase
    if (src.power_up) begin
      state_next = sys_reset_pkg::ST_POR;
    end
  end

  always_ff @(posedge CLOCK_I or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= sys_reset_pkg::ST_POR;
      hold_reg <= '0;
    end else begin
      state_reg <= state_next;
      hold_reg <= hold_next;
    end
  end

  // ****************************************************************
  // Output decode
  // ****************************************************************
  logic in_reset;
  logic running;
  logic pll_reset_next;
  logic low_power_next;
  logic [GPIO_W-1:0] gpio_oe_next;
  sys_reset_pkg::proc_ctrl_t ctrl_next;

  assign running = (state_reg == sys_reset_pkg::ST_RUN);
  assign in_reset = !running;
  // PLL held in reset only before power-up bring-up
  assign pll_reset_next = (state_reg == sys_reset_pkg::ST_POR);
  // Normal mode while in reset; low power only by request
  assign low_power_next = running && PROC_CTRL_I.low_power_req;
  assign gpio_oe_next = running ? GPIO_CFG_OE_I : '0;
  // Block resets follow processor once running
  assign ctrl_next = running ? PROC_CTRL_I : '0;

  // ****************************************************************
  // Output registers
  // ****************************************************************
  // Every system reset re-arms the safe state; processor and master PLL resets
  // are the only ones freed by hardware, all others wait for the processor.
  always_ff @(posedge CLOCK_I or negedge rst_n) begin
    if (!rst_n) begin
      MASTER_PLL_RESET_O <= 1'b1;
      POWER_MODE_O <= sys_reset_pkg::POWER_MODE_NORMAL;
      GPIO_OE_O <= '0;
      MAIN_CLK_EN_O <= '0;
      PROC_FULL_RATE_O <= 1'b1;
      PROC_RESET_N_O <= '0;
      BLOCK_RESET_N_O <= '0;
      EXT_RESET_N_O <= '0;
      LINK_PLL_POWER_DOWN_O <= 1'b1;
      LINK_CLKGEN_RESET_N_O <= 1'b0;
      LINK_PADS_POWER_DOWN_O <= 1'b1;
      FRONT_CLK_EN_O <= '0;
      SYS_RESET_ACTIVE_O <= 1'b1;
    end else begin
      MASTER_PLL_RESET_O <= pll_reset_next;
      POWER_MODE_O <= low_power_next ? sys_reset_pkg::POWER_MODE_LOW
                                     : sys_reset_pkg::POWER_MODE_NORMAL;
      GPIO_OE_O <= gpio_oe_next;
      // Derived clocks run once PLL up
      MAIN_CLK_EN_O <= {sys_reset_pkg::MAIN_CLOCKS{!pll_reset_next
                        && state_reg != sys_reset_pkg::ST_PLL_START}};
      PROC_FULL_RATE_O <= 1'b1;
      PROC_RESET_N_O <= {sys_reset_pkg::PROC_RESETS{running}};
      BLOCK_RESET_N_O <= ctrl_next.block_release;
      EXT_RESET_N_O <= ctrl_next.ext_release;
      // Link PLL and clock gen held until processor frees them
      LINK_PLL_POWER_DOWN_O <= !ctrl_next.link_pll_enable;
      LINK_CLKGEN_RESET_N_O <= ctrl_next.link_clkgen_release;
      LINK_PADS_POWER_DOWN_O <= !ctrl_next.link_pads_enable;
      FRONT_CLK_EN_O <= ctrl_next.front_clk_enable;
      SYS_RESET_ACTIVE_O <= in_reset;
    end
  end

endmodule : sys_reset_ctrl

// ---- verif/sys_reset_ctrl_asserts.sv ----
/* Port checker for sys_reset_ctrl.
   Assumes it is bound into every instance of the controller. */
module sys_reset_ctrl_asserts #(
  parameter int GPIO_W = 83
) (
  input wire logic CLOCK_I,
  input wire logic RST_N_I,
  input wire sys_reset_pkg::reset_src_t SOURCES_I,
  input wire logic MASTER_PLL_RESET_O,
  input wire logic POWER_MODE_O,
  input wire logic [GPIO_W-1:0] GPIO_OE_O,
  input wire logic [7:0] MAIN_CLK_EN_O,
  input wire logic PROC_FULL_RATE_O,
  input wire logic [3:0] PROC_RESET_N_O,
  input wire logic [7:0] BLOCK_RESET_N_O,
  input wire logic [1:0] EXT_RESET_N_O,
  input wire logic LINK_PLL_POWER_DOWN_O,
  input wire logic LINK_CLKGEN_RESET_N_O,
  input wire logic LINK_PADS_POWER_DOWN_O,
  input wire logic [3:0] FRONT_CLK_EN_O,
  input wire logic SYS_RESET_ACTIVE_O
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (!RST_N_I);
  logic [2:0] pu_age;
  wire act = SYS_RESET_ACTIVE_O;
  // Cycles since power-up was last seen, saturating
  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      pu_age <= 3'h0;
    end else if (SOURCES_I.power_up) begin
      pu_age <= 3'h0;
    end else if (pu_age != 3'h7) begin
      pu_age <= pu_age + 3'h1;
    end
  end
  a_gpio_tristate: assert property (act |-> GPIO_OE_O == '0)
    else $error("gpio driven in reset");
  a_mode_normal: assert property (act |-> POWER_MODE_O == 1'b0)
    else $error("low power in reset");
  a_pll_power_only: assert property
    ($rose(MASTER_PLL_RESET_O) |-> pu_age < 3'h6)
    else $error("master pll reset without power-up");
  a_others_held: assert property
    (act |-> BLOCK_RESET_N_O == '0 && EXT_RESET_N_O == '0)
    else $error("block reset freed in reset");
  a_link_safe: assert property (act |-> LINK_PLL_POWER_DOWN_O &&
    !LINK_CLKGEN_RESET_N_O && LINK_PADS_POWER_DOWN_O)
    else $error("link not safe in reset");
  a_front_off: assert property
    (act |-> FRONT_CLK_EN_O == '0 && PROC_FULL_RATE_O)
    else $error("front clocks or rate wrong");
  a_clocks_kept: assert property
    (!act ##1 act && !MASTER_PLL_RESET_O |-> MAIN_CLK_EN_O != '0)
    else $error("clocks gated on warm reset");
  a_proc_release: assert property ($fell(act) |->
    PROC_RESET_N_O == '1 && BLOCK_RESET_N_O == '0)
    else $error("wrong resets released");
  a_source_merge: assert property
    (SOURCES_I.watchdog && !act |-> ##[1:6] act)
    else $error("watchdog not merged");
  c_run: cover property ($fell(act));
  c_warm: cover property ($rose(act) && !MASTER_PLL_RESET_O);
  c_ext: cover property ($rose(EXT_RESET_N_O[0]));
endmodule : sys_reset_ctrl_asserts

bind sys_reset_ctrl sys_reset_ctrl_asserts #(.GPIO_W(GPIO_W)) u_chk (.*);

// ---- verif/proc_model.sv ----
/* Embedded processor stand-in and master PLL lock.
   Assumes the controller's clock; boots once its reset drops. */
module proc_model #(
  parameter int BOOT_DLY = 6
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic proc_rst_n_i,
  input wire logic pll_rst_i,
  output sys_reset_pkg::proc_ctrl_t ctrl_o,
  output logic lock_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] boot_reg;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      boot_reg <= 8'h00;
      lock_o <= 1'b0;
    end else begin
      lock_o <= !pll_rst_i;
      boot_reg <= proc_rst_n_i ? boot_reg + 8'(boot_reg != 8'hff) : 8'h00;
    end
  end
  // Boot frees all, asks low power
  assign ctrl_o = (boot_reg >= 8'(BOOT_DLY)) ? '1 : '0;
endmodule : proc_model

// ---- verif/system_reset_state_control_tb.sv ----
/* Self-checking bench for sys_reset_ctrl.
   Assumes proc_model stands for the processor and PLL. */
module system_reset_state_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int GW = sys_reset_pkg::GPIO_COUNT;
  logic clk, rst_n, lock, pll, pm, fr, act, lpd, lcr, ppd;
  sys_reset_pkg::reset_src_t src;
  sys_reset_pkg::proc_ctrl_t ctrl;
  logic [GW-1:0] cfg, oe;
  logic [7:0] mclk, brst;
  logic [3:0] prst, fclk;
  logic [1:0] erst;
  int error_cnt = 0, cmp_count = 0, cyc = 0;
  sys_reset_ctrl #(.HOLD_CYCLES(4)) uut (.CLOCK_I(clk), .RST_N_I(rst_n),
    .SOURCES_I(src), .MASTER_PLL_LOCK_I(lock), .PROC_CTRL_I(ctrl),
    .GPIO_CFG_OE_I(cfg), .MASTER_PLL_RESET_O(pll), .POWER_MODE_O(pm),
    .GPIO_OE_O(oe), .MAIN_CLK_EN_O(mclk), .PROC_FULL_RATE_O(fr),
    .PROC_RESET_N_O(prst), .BLOCK_RESET_N_O(brst), .EXT_RESET_N_O(erst),
    .LINK_PLL_POWER_DOWN_O(lpd), .LINK_CLKGEN_RESET_N_O(lcr),
    .LINK_PADS_POWER_DOWN_O(ppd), .FRONT_CLK_EN_O(fclk),
    .SYS_RESET_ACTIVE_O(act));
  proc_model u_proc (.clk_i(clk), .rst_n_i(rst_n), .proc_rst_n_i(prst[0]),
    .pll_rst_i(pll), .ctrl_o(ctrl), .lock_o(lock));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Whole run needs well under a thousand cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      close_out();
    end
  end
  task automatic chk(input string n, input logic [95:0] e,
                     input logic [95:0] g);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask : chk
  task automatic wait_act(input logic v);
    int i;
    i = 0;
    while (act !== v && i < 300) begin
      @(posedge clk);
      #1;
      i++;
    end
    chk("active", 96'(v), 96'(act));
  endtask : wait_act
  task automatic t_safe();
    chk("oe", 0, oe);
    chk("mode", 0, pm);
    chk("ext", 0, {brst, erst});
    chk("link", 3'h5, {lpd, lcr, ppd});
    chk("front", 5'h1, {fclk, fr});
    $display("safe state test done");
  endtask : t_safe
  task automatic t_boot();
    wait_act(1'b0);
    chk("pll", 0, pll);
    chk("proc", 12'hf00, {prst, brst});
    repeat (10) @(posedge clk);
    #1;
    chk("free", 10'h3ff, {brst, erst});
    chk("link_run", 3'h2, {lpd, lcr, ppd});
    chk("front_run", 5'h1f, {fclk, fr});
    chk("mclk_run", 8'hff, mclk);
    chk("oe_run", 96'(cfg), 96'(oe));
    chk("mode_run", 1, pm);
    $display("boot test done");
  endtask : t_boot
  task automatic t_src(input int k);
    @(posedge clk) src <= sys_reset_pkg::reset_src_t'(4'(1 << k));
    wait_act(1'b1);
    t_safe();
    chk("pll_warm", 0, pll);
    chk("mclk_on", 1, |mclk);
    @(posedge clk) src <= '0;
    t_boot();
    $display("source test done");
  endtask : t_src
  task automatic t_pwr();
    @(posedge clk) src <= 4'h8;
    wait_act(1'b1);
    repeat (3) @(posedge clk);
    #1;
    chk("pll_cold", 1, pll);
    @(posedge clk) src <= '0;
    t_boot();
    $display("power-up test done");
  endtask : t_pwr
  task automatic close_out();
    $display("counts: %0d mismatches, %0d compares", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : close_out
  initial begin
    rst_n = 1'b0;
    src = '0;
    cfg = 83'h1234_5678_9abc_def0_1234;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    t_safe();
    t_boot();
    for (int k = 0; k < 3; k++) t_src(k);
    t_pwr();
    close_out();
  end
endmodule : system_reset_state_control_tb
